// ==== bmf_mem_model.sv ====
// data memory model facing the bit manipulation unit
// assumes a same-cycle read and an 8-bit address window
`timescale 1ns/100ps
module bmf_mem_model
  import bmf_pkg::*;
(
  // clock
  input wire logic mclk,
  // unit side
  input bmf_res_t res,
  output logic [7:0] memRdata
);
  logic [7:0] mem [256];
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  // released data shows the inverse of the addressed byte
  assign memRdata = res.memRe ? mem[res.memAddr[7:0]] : ~mem[res.memAddr[7:0]];
  always @(posedge mclk)
  begin
    if (res.memWe) mem[res.memAddr[7:0]] <= res.memData;
  end
endmodule

// ==== bmf_pkg.sv ====
// types for the bit manipulation and flag unit
// assumes bmf_regs.svh for constants
package bmf_pkg;
  typedef enum logic [3:0] {
    BMF_NOP,
    BMF_LOAD_TOGGLE_MEM,
    BMF_ROTATE_LEFT_CARRY,
    BMF_ROTATE_RIGHT_CARRY,
    BMF_IO_BIT_SET,
    BMF_IO_BIT_CLEAR,
    BMF_REG_BIT_TO_TFLAG,
    BMF_TFLAG_TO_REG_BIT,
    BMF_SIGNED_FLAG_SET,
    BMF_SIGNED_FLAG_CLEAR,
    BMF_OVERFLOW_FLAG_SET,
    BMF_OVERFLOW_FLAG_CLEAR,
    BMF_HALF_CARRY_SET,
    BMF_HALF_CARRY_CLEAR
  } bmf_op_t;
  typedef struct packed {
    bmf_op_t op;
    logic [7:0] regVal;
    logic [2:0] bitSel;
    logic [15:0] zPtr;
    logic [5:0] ioAddr;
    logic [7:0] ioVal;
    logic sramTarget;
  } bmf_req_t;
  typedef struct packed {
    logic regWe;
    logic [7:0] regData;
    logic ioWe;
    logic [5:0] ioAddr;
    logic [7:0] ioData;
    logic memRe;
    logic memWe;
    logic [15:0] memAddr;
    logic [7:0] memData;
  } bmf_res_t;
endpackage

// ==== bmf_regs.svh ====
// constants for the bit manipulation and flag unit
// assumes a core clock of 100 MHz and a synchronous active-high reset
`ifndef BMF_REGS_SVH
`define BMF_REGS_SVH
`define BMF_FLAG_C 0
`define BMF_FLAG_Z 1
`define BMF_FLAG_N 2
`define BMF_FLAG_V 3
`define BMF_FLAG_S 4
`define BMF_FLAG_H 5
`define BMF_FLAG_T 6
`define BMF_FLAG_I 7
`define BMF_FLAGS_RESET 8'h00
`define BMF_LAT_CYCLES 2
`define BMF_SRAM_EXTRA 1
`endif

// ==== bmf_unit.sv ====
// execution unit for bit manipulation, bit test and flag operations
// assumes the core holds requests until busy falls and memory answers in one clock
`timescale 1ns/100ps
`include "bmf_regs.svh"
module bmf_unit
  import bmf_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // request
  input wire logic reqValid,
  input bmf_req_t req,
  output logic busy,
  // data memory read data
  input wire logic [7:0] memRdata,
  // results
  output bmf_res_t res,
  output logic done,
  output logic [7:0] statusFlagsReg
);
  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  typedef enum logic [1:0] {BMF_IDLE, BMF_LAT_READ, BMF_LAT_SRAM} bmf_state_t;
  bmf_state_t state_q;
  bmf_req_t hold_q;
  logic [7:0] flags_q;
  logic take;
  assign take = reqValid && (state_q == BMF_IDLE);

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign busy = (state_q != BMF_IDLE);
  assign statusFlagsReg = flags_q;

  // ----------------------------------------
  // load-toggle sequencer
  // ----------------------------------------
  bmf_state_t state_d;
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      BMF_IDLE:
        if (take && req.op == BMF_LOAD_TOGGLE_MEM)
          state_d = req.sramTarget ? BMF_LAT_SRAM : BMF_LAT_READ;
      BMF_LAT_SRAM:
        state_d = BMF_LAT_READ;
      BMF_LAT_READ:
        state_d = BMF_IDLE;
      default:
        state_d = BMF_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      state_q <= BMF_IDLE;
    else
      state_q <= state_d;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      hold_q <= '0;
    else if (take)
      hold_q <= req;
  end

  // ----------------------------------------
  // flags
  // ----------------------------------------
  logic [7:0] rolRes;
  logic [7:0] rorRes;
  assign rolRes = {req.regVal[6:0], flags_q[`BMF_FLAG_C]};
  assign rorRes = {flags_q[`BMF_FLAG_C], req.regVal[7:1]};

  always_ff @(posedge mclk)
  begin
    if (rst)
      flags_q <= `BMF_FLAGS_RESET;
    else if (take)
    begin
      case (req.op)
        BMF_ROTATE_LEFT_CARRY:
        begin
          flags_q[`BMF_FLAG_C] <= req.regVal[7];
          flags_q[`BMF_FLAG_Z] <= (rolRes == 8'h00);
          flags_q[`BMF_FLAG_N] <= rolRes[7];
          flags_q[`BMF_FLAG_V] <= rolRes[7] ^ req.regVal[7];
          flags_q[`BMF_FLAG_S] <= rolRes[7] ^ rolRes[7] ^ req.regVal[7];
          flags_q[`BMF_FLAG_H] <= req.regVal[3];
        end
        BMF_ROTATE_RIGHT_CARRY:
        begin
          flags_q[`BMF_FLAG_C] <= req.regVal[0];
          flags_q[`BMF_FLAG_Z] <= (rorRes == 8'h00);
          flags_q[`BMF_FLAG_N] <= rorRes[7];
          flags_q[`BMF_FLAG_V] <= rorRes[7] ^ req.regVal[0];
          flags_q[`BMF_FLAG_S] <= req.regVal[0];
        end
        BMF_REG_BIT_TO_TFLAG:
          flags_q[`BMF_FLAG_T] <= req.regVal[req.bitSel];
        BMF_SIGNED_FLAG_SET:
          flags_q[`BMF_FLAG_S] <= 1'b1;
        BMF_SIGNED_FLAG_CLEAR:
          flags_q[`BMF_FLAG_S] <= 1'b0;
        BMF_OVERFLOW_FLAG_SET:
          flags_q[`BMF_FLAG_V] <= 1'b1;
        BMF_OVERFLOW_FLAG_CLEAR:
          flags_q[`BMF_FLAG_V] <= 1'b0;
        BMF_HALF_CARRY_SET:
          flags_q[`BMF_FLAG_H] <= 1'b1;
        BMF_HALF_CARRY_CLEAR:
          flags_q[`BMF_FLAG_H] <= 1'b0;
        default:
          flags_q <= flags_q;
      endcase
    end
  end

  // ----------------------------------------
  // bit decoding
  // ----------------------------------------
  function automatic logic [7:0] bitMask(logic [2:0] sel);
    bitMask = 8'h01 << sel;
  endfunction

  logic [7:0] ioSetData;
  logic [7:0] ioClearData;
  logic [7:0] tLoadData;
  logic [7:0] latWriteData;
  assign ioSetData = req.ioVal | bitMask(req.bitSel);
  assign ioClearData = req.ioVal & ~bitMask(req.bitSel);
  assign tLoadData = flags_q[`BMF_FLAG_T] ? (req.regVal | bitMask(req.bitSel))
    : (req.regVal & ~bitMask(req.bitSel));
  assign latWriteData = hold_q.regVal ^ memRdata;

  // ----------------------------------------
  // results
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      res <= '0;
      done <= 1'b0;
    end
    else
    begin
      res <= '0;
      done <= 1'b0;
      if (take)
      begin
        res.ioAddr <= req.ioAddr;
        res.memAddr <= req.zPtr;
        case (req.op)
          BMF_LOAD_TOGGLE_MEM:
            res.memRe <= ~req.sramTarget;
          BMF_ROTATE_LEFT_CARRY:
          begin
            res.regWe <= 1'b1;
            res.regData <= rolRes;
            done <= 1'b1;
          end
          BMF_ROTATE_RIGHT_CARRY:
          begin
            res.regWe <= 1'b1;
            res.regData <= rorRes;
            done <= 1'b1;
          end
          BMF_IO_BIT_SET:
          begin
            res.ioWe <= 1'b1;
            res.ioData <= ioSetData;
            done <= 1'b1;
          end
          BMF_IO_BIT_CLEAR:
          begin
            res.ioWe <= 1'b1;
            res.ioData <= ioClearData;
            done <= 1'b1;
          end
          BMF_TFLAG_TO_REG_BIT:
          begin
            res.regWe <= 1'b1;
            res.regData <= tLoadData;
            done <= 1'b1;
          end
          BMF_REG_BIT_TO_TFLAG,
          BMF_SIGNED_FLAG_SET,
          BMF_SIGNED_FLAG_CLEAR,
          BMF_OVERFLOW_FLAG_SET,
          BMF_OVERFLOW_FLAG_CLEAR,
          BMF_HALF_CARRY_SET,
          BMF_HALF_CARRY_CLEAR:
            done <= 1'b1;
          default:
            done <= 1'b0;
        endcase
      end
      else if (state_q == BMF_LAT_SRAM)
      begin
        res.memRe <= 1'b1;
        res.memAddr <= hold_q.zPtr;
      end
      else if (state_q == BMF_LAT_READ)
      begin
        res.memWe <= 1'b1;
        res.memAddr <= hold_q.zPtr;
        res.memData <= latWriteData;
        res.regWe <= 1'b1;
        res.regData <= memRdata;
        done <= 1'b1;
      end
    end
  end
endmodule

// ==== bmf_unit_sva.sv ====
// assertions on the ports of bmf_unit
// assumes bmf_pkg op codes
`timescale 1ns/100ps
module bmf_unit_sva
  import bmf_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // ports watched
  input wire logic reqValid,
  input bmf_req_t req,
  input wire logic busy,
  input bmf_res_t res,
  input wire logic done,
  input wire logic [7:0] statusFlagsReg
);
  wire tk = reqValid && !busy;
  wire [7:0] sf = statusFlagsReg;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_lat_timing: assert property (tk && req.op == BMF_LOAD_TOGGLE_MEM && !req.sramTarget
    |=> res.memRe && busy ##1 done && res.memWe && sf == $past(sf, 2)) else $error("lat");
  a_lat_sram: assert property (tk && req.op == BMF_LOAD_TOGGLE_MEM && req.sramTarget
    |=> !res.memRe ##1 res.memRe ##1 done && res.memWe) else $error("sram");
  a_rol_result: assert property (tk && req.op == BMF_ROTATE_LEFT_CARRY |=> done &&
    res.regData == {$past(req.regVal[6:0]), $past(sf[0])} && sf[0] == $past(req.regVal[7]))
    else $error("rol");
  a_ror_result: assert property (tk && req.op == BMF_ROTATE_RIGHT_CARRY |=> done &&
    res.regData == {$past(sf[0]), $past(req.regVal[7:1])} && sf[0] == $past(req.regVal[0]))
    else $error("ror");
  a_io_set: assert property (tk && req.op == BMF_IO_BIT_SET |=> res.ioWe && sf == $past(sf)
    && res.ioData == ($past(req.ioVal) | (8'h01 << $past(req.bitSel)))) else $error("set");
  a_io_clear: assert property (tk && req.op == BMF_IO_BIT_CLEAR |=> res.ioWe &&
    res.ioData == ($past(req.ioVal) & ~(8'h01 << $past(req.bitSel)))) else $error("clr");
  a_tflag_store: assert property (tk && req.op == BMF_REG_BIT_TO_TFLAG
    |=> (sf & 8'hbf) == ($past(sf) & 8'hbf) && sf[6] == $past(req.regVal[req.bitSel]))
    else $error("bst");
  a_tflag_load: assert property (tk && req.op == BMF_TFLAG_TO_REG_BIT
    |=> res.regWe && sf == $past(sf)) else $error("bld");
  a_sflag_set: assert property (tk && req.op == BMF_SIGNED_FLAG_SET
    |=> sf == ($past(sf) | 8'h10)) else $error("ses");
endmodule
bind bmf_unit bmf_unit_sva i_bmf_unit_sva (.mclk(mclk), .rst(rst), .reqValid(reqValid),
  .req(req), .busy(busy), .res(res), .done(done), .statusFlagsReg(statusFlagsReg));

// ==== tb_bit_manip_flag_unit.sv ====
// self-checking bench for bmf_unit
// assumes bmf_mem_model as data memory
`timescale 1ns/100ps
module tb_bit_manip_flag_unit;
  import bmf_pkg::*;
  logic mclk = 0, rst = 1, reqValid = 0, busy, done;
  bmf_req_t req = '0;
  bmf_res_t res;
  logic [7:0] memRdata, statusFlagsReg, f = 0, m [256];
  int num_errors = 0, tests_run = 0;
  logic [31:0] sd = 32'h0000_c7cb;
  bmf_unit i_bmf_unit (.mclk(mclk), .rst(rst), .reqValid(reqValid), .req(req), .busy(busy),
    .memRdata(memRdata), .res(res), .done(done), .statusFlagsReg(statusFlagsReg));
  bmf_mem_model i_bmf_mem_model (.mclk(mclk), .res(res), .memRdata(memRdata));
  initial forever #5 mclk = ~mclk;
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(logic [7:0] s, logic [7:0] e);
    tests_run++;
    if (s !== e)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic run(bmf_op_t o, logic [7:0] v, logic [2:0] b);
    logic [7:0] r = v;
    logic [7:0] e = ~v;
    req = '{o, v, b, 16'h0000, 6'(b), ~v, 1'b0};
    reqValid = 1;
    case (o)
      BMF_ROTATE_LEFT_CARRY: {f[5], f[0], r} = {v[3], v, f[0]};
      BMF_ROTATE_RIGHT_CARRY: {r, f[0]} = {f[0], v};
      BMF_IO_BIT_SET: e[b] = 1'b1;
      BMF_IO_BIT_CLEAR: e[b] = 1'b0;
      BMF_REG_BIT_TO_TFLAG: f[6] = v[b];
      BMF_TFLAG_TO_REG_BIT: r[b] = f[6];
      BMF_SIGNED_FLAG_SET: f[4] = 1'b1;
      BMF_SIGNED_FLAG_CLEAR: f[4] = 1'b0;
      BMF_OVERFLOW_FLAG_SET: f[3] = 1'b1;
      BMF_OVERFLOW_FLAG_CLEAR: f[3] = 1'b0;
      BMF_HALF_CARRY_SET: f[5] = 1'b1;
      BMF_HALF_CARRY_CLEAR: f[5] = 1'b0;
      default: ;
    endcase
    if (o inside {BMF_ROTATE_LEFT_CARRY, BMF_ROTATE_RIGHT_CARRY})
      {f[4], f[3], f[2], f[1]} = {f[0], r[7] ^ f[0], r[7], r == 8'h00};
    @(posedge mclk);
    #1;
    chk(8'(done), 8'h01);
    chk(8'(res.regWe), 8'(o inside {BMF_ROTATE_LEFT_CARRY, BMF_ROTATE_RIGHT_CARRY,
      BMF_TFLAG_TO_REG_BIT}));
    chk(8'(res.ioWe), 8'(o inside {BMF_IO_BIT_SET, BMF_IO_BIT_CLEAR}));
    chk(8'(res.ioAddr), 8'(b));
    chk(statusFlagsReg, f);
    if (o inside {BMF_ROTATE_LEFT_CARRY, BMF_ROTATE_RIGHT_CARRY, BMF_TFLAG_TO_REG_BIT})
      chk(res.regData, r);
    if (o inside {BMF_IO_BIT_SET, BMF_IO_BIT_CLEAR}) chk(res.ioData, e);
  endtask
  task automatic lat(logic [7:0] v, logic [7:0] a, logic s);
    int n = 1;
    req = '{BMF_LOAD_TOGGLE_MEM, v, 3'h0, {8'h00, a}, 6'h00, 8'h00, s};
    reqValid = 1;
    @(posedge mclk);
    #1;
    reqValid = 0;
    while (done !== 1'b1 && n < 8)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(8'(n), 8'(2 + s));
    chk(res.memData, v ^ m[a]);
    chk(res.regData, m[a]);
    chk(res.memAddr[7:0], a);
    chk(8'(res.memWe), 8'h01);
    chk(statusFlagsReg, f);
    m[a] = v ^ m[a];
  endtask
  initial
  begin
    for (int i = 0; i < 256; i++) m[i] = 8'(i) ^ 8'h5a;
    repeat (3) @(posedge mclk);
    #1;
    rst = 0;
    for (int k = 0; k < 400; k++)
    begin
      sd = lfsr(sd);
      if (k % 50 == 7) lat(sd[15:8], sd[7:0], sd[3]);
      else run(bmf_op_t'(4'(2 + sd % 12)), sd[15:8], sd[2:0]);
    end
    lat(8'hff, 8'h10, 1'b0);
    lat(8'h3c, 8'h10, 1'b1);
    summarize;
  end
  initial
  begin
    #50000;
    num_errors++;
    summarize;
  end
endmodule
